// [verilog/sirqm_pkg.sv]
`default_nettype none

package sirqm_pkg;

  // Register map on the microcontroller port
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] CTRL_ADDR = 16'h7F52;
  localparam logic [15:0] STAT_ADDR = 16'h7F90;
  localparam logic [15:0] MASK_ADDR = 16'h7F91;
  localparam logic [15:0] LINK_ADDR = 16'h7F92;

  // Control register layout and reset
  localparam int SEL_LSB = 4;
  localparam int SEL_W = 4;
  localparam int EN_BIT = 3;
  localparam int REQ_BIT = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WR_MASK = 8'hFC;
  localparam logic [3:0] SEL_NONE = 4'h0;

  // Event bits of the status and mask registers
  localparam int EV_SLOT = 0;
  localparam int EV_FRAME = 1;
  localparam int EV_BADSTART = 2;
  localparam int EV_W = 3;
  localparam logic [2:0] EV_RESET = 3'h0;

  // Serial interrupt frame timing, in clocks, and slot counter preset
  localparam logic [3:0] START_MIN = 4'h4;
  localparam logic [3:0] LOW_CNT_MAX = 4'hF;
  localparam logic [4:0] SLOT_PRE = 5'h1F;

  typedef struct packed {
    logic [3:0] sel;
    logic en;
    logic req;
    logic [1:0] rsvd;
  } sirqm_ctrl_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_SLOT = 3'b010,
    ST_STOP = 3'b011,
    ST_STOPLOW = 3'b100
  } sirqm_state_t;

  typedef enum logic [1:0] {
    PH_SAMPLE = 2'b00,
    PH_RECOV = 2'b01,
    PH_TURN = 2'b10
  } sirqm_phase_t;

endpackage : sirqm_pkg

`default_nettype wire

// [verilog/sirqm_irq_mapper.sv]
// Overview of operation
// - Four-bit select picks line one-fifteen; zero none.
// - Enable bit must be set to drive any slot low.
// - With enable set, selected line asserted only while request bit set.
// - Disabled mapping leaves line in asserted state.
// - Software alone sets and clears the request.
// - Control resets zero; low two bits read-only.
`default_nettype none

module sirqm_irq_mapper #(
  parameter int SLOT_COUNT = 16
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Serial interrupt line, driven low, then high for one clock, else released
  input wire logic serirq_in,
  output logic serirq_out,
  output logic serirq_oe_n,
  // Interrupt to the microcontroller
  output logic irq
);

  generate
    if (SLOT_COUNT < 16 || SLOT_COUNT > 31)
    begin : g_bad_slot_count
      $error("SLOT_COUNT must lie between 16 and 31");
    end
  endgenerate

  localparam logic [4:0] LAST_SLOT = 5'(SLOT_COUNT - 1);

  sirqm_pkg::sirqm_ctrl_t ctrl_reg;
  logic [sirqm_pkg::EV_W-1:0] status_reg;
  logic [sirqm_pkg::EV_W-1:0] status_next;
  logic [sirqm_pkg::EV_W-1:0] mask_reg;
  logic [sirqm_pkg::EV_W-1:0] event_set;
  logic [sirqm_pkg::EV_W-1:0] event_clr;
  sirqm_pkg::sirqm_state_t state_reg;
  sirqm_pkg::sirqm_state_t state_next;
  sirqm_pkg::sirqm_phase_t phase_reg;
  sirqm_pkg::sirqm_phase_t phase_next;
  logic [4:0] slot_reg;
  logic [4:0] slot_next;
  logic [3:0] low_cnt_reg;
  logic frame_done;
  logic bad_start;
  logic mapped;
  logic in_sample;
  logic drive_low;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic serirq_out_reg;
  logic serirq_oe_n_reg;
  logic irq_reg;

  logic wr_ctrl;
  logic wr_stat;
  logic wr_mask;

  assign wr_ctrl = wr && (addr == sirqm_pkg::CTRL_ADDR);
  assign wr_stat = wr && (addr == sirqm_pkg::STAT_ADDR);
  assign wr_mask = wr && (addr == sirqm_pkg::MASK_ADDR);

  // Control register: written only by software
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ctrl_reg <= sirqm_pkg::sirqm_ctrl_t'(sirqm_pkg::CTRL_RESET);
    end
    else if (wr_ctrl)
    begin
      ctrl_reg <= sirqm_pkg::sirqm_ctrl_t'(wdata & sirqm_pkg::CTRL_WR_MASK);
    end
  end

  // Frame tracker
  always_comb
  begin
    state_next = state_reg;
    phase_next = phase_reg;
    slot_next = slot_reg;
    frame_done = 1'b0;
    bad_start = 1'b0;
    case (state_reg)
      sirqm_pkg::ST_IDLE:
      begin
        if (!serirq_in)
        begin
          state_next = sirqm_pkg::ST_START;
        end
      end
      sirqm_pkg::ST_START:
      begin
        if (serirq_in)
        begin
          if (low_cnt_reg >= sirqm_pkg::START_MIN)
          begin
            // The clock just seen high was the recovery; turnaround comes next
            state_next = sirqm_pkg::ST_SLOT;
            phase_next = sirqm_pkg::PH_TURN;
            slot_next = sirqm_pkg::SLOT_PRE;
          end
          else
          begin
            state_next = sirqm_pkg::ST_IDLE;
            bad_start = 1'b1;
          end
        end
      end
      sirqm_pkg::ST_SLOT:
      begin
        case (phase_reg)
          sirqm_pkg::PH_SAMPLE:
          begin
            phase_next = sirqm_pkg::PH_RECOV;
          end
          sirqm_pkg::PH_RECOV:
          begin
            phase_next = sirqm_pkg::PH_TURN;
          end
          sirqm_pkg::PH_TURN:
          begin
            if (slot_reg == LAST_SLOT)
            begin
              state_next = sirqm_pkg::ST_STOP;
            end
            else
            begin
              phase_next = sirqm_pkg::PH_SAMPLE;
              slot_next = slot_reg + 5'h01;
            end
          end
          default:
          begin
            phase_next = sirqm_pkg::PH_SAMPLE;
          end
        endcase
      end
      sirqm_pkg::ST_STOP:
      begin
        if (!serirq_in)
        begin
          state_next = sirqm_pkg::ST_STOPLOW;
        end
      end
      sirqm_pkg::ST_STOPLOW:
      begin
        if (serirq_in)
        begin
          state_next = sirqm_pkg::ST_IDLE;
          frame_done = 1'b1;
        end
      end
      default:
      begin
        state_next = sirqm_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_reg <= sirqm_pkg::ST_IDLE;
      phase_reg <= sirqm_pkg::PH_SAMPLE;
      slot_reg <= 5'h00;
    end
    else
    begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      slot_reg <= slot_next;
    end
  end

  // Start frame length, counted from the first low clock
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      low_cnt_reg <= 4'h0;
    end
    else if (state_reg != sirqm_pkg::ST_START)
    begin
      low_cnt_reg <= 4'h1;
    end
    else if (!serirq_in && low_cnt_reg != sirqm_pkg::LOW_CNT_MAX)
    begin
      low_cnt_reg <= low_cnt_reg + 4'h1;
    end
  end

  // Slot ownership for the coming clock
  assign mapped = ctrl_reg.en
    && (ctrl_reg.sel != sirqm_pkg::SEL_NONE)
    && (slot_next == {1'b0, ctrl_reg.sel});
  assign in_sample = (state_next == sirqm_pkg::ST_SLOT)
    && (phase_next == sirqm_pkg::PH_SAMPLE);
  // Low in the sample phase reports the line deasserted; released means asserted
  assign drive_low = mapped && in_sample && !ctrl_reg.req;

  // Line driver: sample low, one recovery clock high, then release
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      serirq_out_reg <= 1'b1;
      serirq_oe_n_reg <= 1'b1;
    end
    else if (drive_low)
    begin
      serirq_out_reg <= 1'b0;
      serirq_oe_n_reg <= 1'b0;
    end
    else if (!serirq_oe_n_reg && !serirq_out_reg)
    begin
      serirq_out_reg <= 1'b1;
      serirq_oe_n_reg <= 1'b0;
    end
    else
    begin
      serirq_out_reg <= 1'b1;
      serirq_oe_n_reg <= 1'b1;
    end
  end

  // Events and write-one-to-clear status, set wins over clear
  assign event_set[sirqm_pkg::EV_SLOT] = mapped && in_sample && ctrl_reg.req;
  assign event_set[sirqm_pkg::EV_FRAME] = frame_done;
  assign event_set[sirqm_pkg::EV_BADSTART] = bad_start;
  assign event_clr = wr_stat ? wdata[sirqm_pkg::EV_W-1:0] : {sirqm_pkg::EV_W{1'b0}};

  genvar gi;
  generate
    for (gi = 0; gi < sirqm_pkg::EV_W; gi++)
    begin : g_status
      assign status_next[gi] = event_set[gi] || (status_reg[gi] && !event_clr[gi]);
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      status_reg <= sirqm_pkg::EV_RESET;
    end
    else
    begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      mask_reg <= sirqm_pkg::EV_RESET;
    end
    else if (wr_mask)
    begin
      mask_reg <= wdata[sirqm_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      irq_reg <= 1'b0;
    end
    else
    begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // Read data for one cycle only; unmapped addresses read zero
  always_comb
  begin
    rdata_next = 8'h00;
    if (rd)
    begin
      case (addr)
        sirqm_pkg::CTRL_ADDR:
        begin
          rdata_next = ctrl_reg & sirqm_pkg::CTRL_WR_MASK;
        end
        sirqm_pkg::STAT_ADDR:
        begin
          rdata_next = {{(8 - sirqm_pkg::EV_W){1'b0}}, status_reg};
        end
        sirqm_pkg::MASK_ADDR:
        begin
          rdata_next = {{(8 - sirqm_pkg::EV_W){1'b0}}, mask_reg};
        end
        sirqm_pkg::LINK_ADDR:
        begin
          rdata_next = {state_reg, slot_reg};
        end
        default:
        begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;
  assign serirq_out = serirq_out_reg;
  assign serirq_oe_n = serirq_oe_n_reg;
  assign irq = irq_reg;

endmodule : sirqm_irq_mapper

`default_nettype wire

// [tb/sirqm_irq_mapper_asserts.sv]
`default_nettype none
module sirqm_chk
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Register port
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Serial line and interrupt
  input wire logic serirq_in,
  input wire logic serirq_out,
  input wire logic serirq_oe_n,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] c_reg;
  // Mirror of the control register
  always_ff @(posedge clk)
    if (!reset_n)
      c_reg <= 8'h00;
    else if (wr && addr == sirqm_pkg::CTRL_ADDR)
      c_reg <= wdata & sirqm_pkg::CTRL_WR_MASK;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_sel; !serirq_oe_n |-> c_reg[7:4] != 4'h0; endproperty
  a_sel: assert property (p_sel) else $error("line driven with no select");
  property p_en; !c_reg[3] |-> serirq_oe_n; endproperty
  a_en: assert property (p_en) else $error("line driven while disabled");
  property p_req; c_reg[2] |-> serirq_oe_n; endproperty
  a_req: assert property (p_req) else $error("line driven while requesting");
  property p_dflt; !serirq_oe_n && !serirq_out |-> c_reg[3] && !c_reg[2]; endproperty
  a_dflt: assert property (p_dflt) else $error("line pulled low wrongly");
  property p_frm;
    !serirq_oe_n && !serirq_out |=> !serirq_oe_n && serirq_out ##1 serirq_oe_n;
  endproperty
  a_frm: assert property (p_frm) else $error("slot drive pattern wrong");
  property p_rd; rd && addr == sirqm_pkg::CTRL_ADDR |=> rdata == c_reg; endproperty
  a_rd: assert property (p_rd) else $error("control read back wrong");
  property p_idle; !$past(rd) |-> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero");
endmodule : sirqm_chk
`default_nettype wire

// [tb/sirqm_host.sv]
`default_nettype none
module sirqm_host #(
  parameter int N = 16
)
(
  // Clock and frame start
  input wire logic clk,
  input wire logic go,
  // Wire level, host drive, sampled slots
  input wire logic sio,
  output logic host_low,
  output logic [31:0] seen
);
  timeunit 1ns;
  timeprecision 1ns;
  int t = -1;
  // Four low clocks of start, two of stop
  assign host_low = (t >= 0 && t < 4) || (t >= 3 * N + 6 && t < 3 * N + 8);
  always @(posedge clk)
  begin
    if (go)
      t <= 0;
    else if (t >= 0)
      t <= (t == 3 * N + 10) ? -1 : t + 1;
    if (t >= 6 && (t - 6) % 3 == 0 && (t - 6) / 3 < N)
      seen[(t - 6) / 3] <= sio;
  end
endmodule : sirqm_host
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int N = 16;
  localparam logic [15:0] CA = sirqm_pkg::CTRL_ADDR;
  logic clk = 0, reset_n = 0, wr = 0, rd = 0, go = 0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic serirq_out, serirq_oe_n, irq, host_low, sio;
  logic [31:0] seen;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  // Wire with pull-up
  assign sio = !(host_low || (!serirq_oe_n && !serirq_out));
  always #10 clk = !clk;
  sirqm_irq_mapper #(.SLOT_COUNT(N)) dut (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serirq_in(sio),
    .serirq_out(serirq_out), .serirq_oe_n(serirq_oe_n), .irq(irq));
  sirqm_host #(.N(N)) host (.clk(clk), .go(go), .sio(sio), .host_low(host_low), .seen(seen));
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  task chk(string s, logic [15:0] e, logic [15:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task wreg(logic [15:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task rreg(logic [15:0] a, logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk("rdata", {8'h00, e}, {8'h00, rdata});
  endtask : rreg
  task frame(logic [15:0] e);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3 * N + 12) @(posedge clk);
    chk("slots", e, seen[15:0]);
  endtask : frame
  task t_irq;
    wreg(sirqm_pkg::STAT_ADDR, 8'h07);
    wreg(sirqm_pkg::MASK_ADDR, 8'h00);
    frame(16'hFFDF);
    #1 chk("irq masked", 16'h0000, {15'h0000, irq});
    wreg(sirqm_pkg::MASK_ADDR, 8'h02);
    @(posedge clk);
    #1 chk("irq set", 16'h0001, {15'h0000, irq});
    wreg(sirqm_pkg::STAT_ADDR, 8'h02);
    @(posedge clk);
    #1 chk("irq clear", 16'h0000, {15'h0000, irq});
  endtask : t_irq
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_mismatch++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rreg(CA, 8'h00);
    rreg(16'h7F00, 8'h00);
    // Every select code, low bits written as ones
    for (int s = 0; s < 16; s++)
    begin
      wreg(CA, {s[3:0], 4'hB});
      rreg(CA, {s[3:0], 4'h8});
      frame(~(16'h0001 << s) | 16'h0001);
    end
    wreg(CA, 8'h50);
    frame(16'hFFFF);
    wreg(CA, 8'h5C);
    frame(16'hFFFF);
    rreg(sirqm_pkg::STAT_ADDR, 8'h03);
    wreg(CA, 8'h58);
    t_irq();
    report_and_stop;
  end
endmodule : tb_top
bind sirqm_irq_mapper sirqm_chk u_chk (.clk(clk), .reset_n(reset_n), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .serirq_in(serirq_in),
  .serirq_out(serirq_out), .serirq_oe_n(serirq_oe_n), .irq(irq));
`default_nettype wire
